// file: timer_bank_pkg.sv
// package for the ten channel reload timer bank: offsets, fields, modes
// assumes a 32-bit AXI4-Lite register bus and one system clock
package timer_bank_pkg;

    localparam int NUM_CH = 10;
    localparam int CNT_W = 16;

    // printed register indices; byte address is four times the index
    localparam logic [7:0] CH_INDEX [NUM_CH] = '{
        8'h46, 8'h48, 8'h4A, 8'h4C, 8'h4E,
        8'hC6, 8'hC8, 8'hCA, 8'hCC, 8'hCE
    };
    // control registers placed above the channel words
    localparam logic [11:0] START_ADDR = 12'h400;
    localparam logic [11:0] CLKDIV_ADDR = 12'h404;
    localparam logic [11:0] STATUS_ADDR = 12'h408;
    localparam logic [11:0] MASK_ADDR = 12'h40C;
    localparam logic [11:0] TRIG_ADDR = 12'h410;
    localparam logic [11:0] MODE_BASE = 12'h440;

    // channel capability masks, bit i for channel i
    localparam logic [9:0] PIN_MASK = 10'h217;
    localparam logic [9:0] TWO_PHASE_MASK = 10'h214;
    localparam logic [9:0] QUAD_MASK = 10'h210;

    // mode register fields
    localparam int MODE_LSB = 0;
    localparam int UP_BIT = 2;
    localparam int GATE_BIT = 3;
    localparam int POUT_BIT = 4;
    localparam int TWOPH_BIT = 5;
    localparam int PWM8_BIT = 6;
    localparam int SRC_LSB = 7;
    localparam int MODE_REG_W = 9;
    localparam logic [MODE_REG_W-1:0] MODE_RESET = 9'h000;
    localparam logic [1:0] CLKDIV_RESET = 2'h0;

    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] PWM16_LAST = 16'hFFFE;
    localparam logic [7:0] PWM8_LAST = 8'hFF;
    localparam int PRE_W = 12;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_TIMER = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_ONESHOT = 2'b10,
        MODE_PWM = 2'b11
    } mode_t;

endpackage : timer_bank_pkg

// file: timer_bank.sv
// ten channel 16-bit reload timer bank with AXI4-Lite register access
// assumes pins arrive asynchronously; one clock aclk, sync reset aresetn
// Function
// R1: ten independent 16-bit counters with reload registers
// R2: channels 3,5-8 timer only; others all modes
// R3: timer counts internal source; gate and pulse output
// R4: event mode counts input edges; optional pulse output
// R5: two-phase on 2 normal, 4 and 9 quadruple
// R6: one-shot emits one pulse per trigger
// R7: PWM emits continuous pulses, 16 or 8 bit
// R8: counter decrements per source; event mode may increment; PWM mode here counts up from zero
// R9: underflow or overflow loads reload value into counter
// R10: write while stopped sets counter and reload
// R11: write while counting sets reload only
// R12: read in timer or event mode returns counter
// R13: read in one-shot or PWM mode is undefined
// R14: software accesses counter register as 16 bits only
// R15: counter and reload undefined after reset
// R16: per-channel start bit, resets to zero
// R17: source from channel select and shared division field
// R18: channel counts exactly while its start bit set
//
// Register access over AXI4-Lite is this design's own decision.
module timer_bank
    import timer_bank_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_CH-1:0] chan_in_a,
    input wire logic [NUM_CH-1:0] chan_in_b,
    output logic [NUM_CH-1:0] chan_out,
    output logic irq
);

    if (ADDR_W < 12) begin : g_bad_addr
        $error("ADDR_W must be at least 12");
    end

    // write channel holding registers
    logic [ADDR_W-1:0] awaddr_q;
    logic aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_have_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;
    logic wr_full;
    logic wr_known;

    // read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_d;
    logic rd_known;
    logic rd_fire;

    // control state
    logic [NUM_CH-1:0] start_q;
    logic [1:0] clkdiv_q;
    logic [NUM_CH-1:0] status_q;
    logic [NUM_CH-1:0] mask_q;
    logic [NUM_CH-1:0] evt;
    logic [NUM_CH-1:0] sw_trig;
    logic [NUM_CH-1:0] ch_wr;
    logic [PRE_W-1:0] pre_q;
    logic [MODE_REG_W-1:0] mode_q [NUM_CH];
    logic [CNT_W-1:0] cnt_q [NUM_CH];
    logic [CNT_W-1:0] rel_q [NUM_CH];
    logic [NUM_CH-1:0] out_q;

    // prescaler exponent from channel select and shared division
    function automatic logic [3:0] src_exp(input logic [1:0] sel,
                                           input logic [1:0] div);
        logic [3:0] e;
        e = 4'h0;
        case ({div, sel})
            4'b0000: e = 4'h1;
            4'b0001: e = 4'h4;
            4'b0010: e = 4'h6;
            4'b0011: e = 4'h9;
            4'b0101: e = 4'h4;
            4'b0110: e = 4'h6;
            4'b0111: e = 4'hC;
            4'b1001: e = 4'h6;
            4'b1010: e = 4'h9;
            4'b1011: e = 4'hC;
            default: e = 4'h0;
        endcase
        return e;
    endfunction : src_exp

    // awready and wready fall once a word is held until the write is done
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign wr_full = (wstrb_q[1:0] == 2'b11);
    assign rd_fire = s_axi_arvalid && !rvalid_q;

    // address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // write address decode
    always_comb begin
        wr_known = 1'b0;
        ch_wr = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (awaddr_q == ADDR_W'({CH_INDEX[i], 2'b00})) begin
                wr_known = 1'b1;
                ch_wr[i] = wr_fire && wr_full; // R14
            end
            if (awaddr_q == ADDR_W'(MODE_BASE) + ADDR_W'(4 * i)) begin
                wr_known = 1'b1;
            end
        end
        if (awaddr_q == ADDR_W'(START_ADDR) ||
            awaddr_q == ADDR_W'(CLKDIV_ADDR) ||
            awaddr_q == ADDR_W'(STATUS_ADDR) ||
            awaddr_q == ADDR_W'(MASK_ADDR) ||
            awaddr_q == ADDR_W'(TRIG_ADDR)) begin
            wr_known = 1'b1;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // control registers; start bits reset to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= '0; // R16
            clkdiv_q <= CLKDIV_RESET;
            mask_q <= '0;
        end else if (wr_fire && wr_full) begin
            if (awaddr_q == ADDR_W'(START_ADDR)) begin
                start_q <= wdata_q[NUM_CH-1:0]; // R16 R18
            end
            if (awaddr_q == ADDR_W'(CLKDIV_ADDR)) begin
                clkdiv_q <= wdata_q[1:0]; // R17
            end
            if (awaddr_q == ADDR_W'(MASK_ADDR)) begin
                mask_q <= wdata_q[NUM_CH-1:0];
            end
        end
    end

    // one-cycle software trigger for one-shot channels
    assign sw_trig = (wr_fire && wr_full &&
        awaddr_q == ADDR_W'(TRIG_ADDR)) ? wdata_q[NUM_CH-1:0] : '0;

    // sticky event status, write one to clear; a new event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= '0;
        end else if (wr_fire && wr_full &&
                     awaddr_q == ADDR_W'(STATUS_ADDR)) begin
            status_q <= (status_q & ~wdata_q[NUM_CH-1:0]) | evt;
        end else begin
            status_q <= status_q | evt;
        end
    end

    assign irq = |(status_q & mask_q);

    // free running prescaler shared by all channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRE_W'(1);
        end
    end

    // read mux; counter words read the live count in every mode
    always_comb begin
        rdata_d = 32'h0000_0000;
        rd_known = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (s_axi_araddr == ADDR_W'({CH_INDEX[i], 2'b00})) begin
                rd_known = 1'b1;
                rdata_d = {16'h0000, cnt_q[i]}; // R12 R13
            end
            if (s_axi_araddr == ADDR_W'(MODE_BASE) + ADDR_W'(4 * i)) begin
                rd_known = 1'b1;
                rdata_d = {23'h000000, mode_q[i]};
            end
        end
        if (s_axi_araddr == ADDR_W'(START_ADDR)) begin
            rd_known = 1'b1;
            rdata_d = {22'h000000, start_q};
        end else if (s_axi_araddr == ADDR_W'(CLKDIV_ADDR)) begin
            rd_known = 1'b1;
            rdata_d = {30'h00000000, clkdiv_q};
        end else if (s_axi_araddr == ADDR_W'(STATUS_ADDR)) begin
            rd_known = 1'b1;
            rdata_d = {22'h000000, status_q};
        end else if (s_axi_araddr == ADDR_W'(MASK_ADDR)) begin
            rd_known = 1'b1;
            rdata_d = {22'h000000, mask_q};
        end else if (s_axi_araddr == ADDR_W'(TRIG_ADDR)) begin
            rd_known = 1'b1;
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rdata_d;
            rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign chan_out = out_q;

    // per channel counter, sync, mode and assertions
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [2:0] sa_q;
        logic [2:0] sb_q;
        logic a_q, b_q, a_p_q, b_p_q;
        logic os_run_q;
        logic [CNT_W-1:0] cnt_d, rel_d;
        logic out_d, os_run_d, tick, a_edge, b_edge, up, step, dn;
        logic [PRE_W-1:0] tmask;
        mode_t md;

        // three stage sync; a level counts once stages two and three agree
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sa_q <= 3'h0;
                sb_q <= 3'h0;
                a_q <= 1'b0;
                b_q <= 1'b0;
                a_p_q <= 1'b0;
                b_p_q <= 1'b0;
            end else begin
                sa_q <= {sa_q[1:0], chan_in_a[i]};
                sb_q <= {sb_q[1:0], chan_in_b[i]};
                if (sa_q[1] == sa_q[2]) a_q <= sa_q[2];
                if (sb_q[1] == sb_q[2]) b_q <= sb_q[2];
                a_p_q <= a_q;
                b_p_q <= b_q;
            end
        end

        // mode register, forced to timer on internal-only channels
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mode_q[i] <= MODE_RESET;
            end else if (wr_fire && wr_full && awaddr_q ==
                         ADDR_W'(MODE_BASE) + ADDR_W'(4 * i)) begin
                mode_q[i] <= PIN_MASK[i] ? wdata_q[MODE_REG_W-1:0]
                           : {wdata_q[8:7], 7'h00}; // R2
            end
        end

        assign md = mode_t'(mode_q[i][MODE_LSB +: 2]);
        assign tmask = PRE_W'((13'h0001 << src_exp(
            mode_q[i][SRC_LSB +: 2], clkdiv_q)) - 13'h0001); // R17
        assign tick = ((pre_q & tmask) == tmask);
        assign a_edge = a_q != a_p_q;
        assign b_edge = b_q != b_p_q;

        // event step and direction for single and two-phase inputs
        always_comb begin
            step = 1'b0;
            up = mode_q[i][UP_BIT]; // R8
            if (TWO_PHASE_MASK[i] && mode_q[i][TWOPH_BIT]) begin
                if (QUAD_MASK[i]) begin // R5
                    step = a_edge ^ b_edge;
                    up = a_edge ? (a_q != b_q) : (b_q == a_q);
                end else begin // R5
                    step = a_edge && a_q;
                    up = b_q;
                end
            end else begin
                step = a_edge && a_q; // R4
            end
        end

        assign dn = !up;

        // counting per mode, then software write on top
        always_comb begin
            cnt_d = cnt_q[i];
            rel_d = rel_q[i];
            out_d = out_q[i];
            os_run_d = os_run_q;
            evt[i] = 1'b0;
            case (md)
                MODE_TIMER: begin
                    if (start_q[i] && tick && (!mode_q[i][GATE_BIT]
                        || a_q)) begin // R3 R18
                        if (cnt_q[i] == 16'h0000) begin
                            cnt_d = rel_q[i]; // R9
                            evt[i] = 1'b1;
                            out_d = out_q[i] ^ mode_q[i][POUT_BIT]; // R3
                        end else begin
                            cnt_d = cnt_q[i] - 16'h0001; // R8
                        end
                    end
                end
                MODE_EVENT: begin
                    if (start_q[i] && step) begin // R4
                        if (up && cnt_q[i] == CNT_MAX ||
                            dn && cnt_q[i] == 16'h0000) begin
                            cnt_d = rel_q[i]; // R9
                            evt[i] = 1'b1;
                            out_d = out_q[i] ^ mode_q[i][POUT_BIT];
                        end else if (up) begin
                            cnt_d = cnt_q[i] + 16'h0001; // R8
                        end else begin
                            cnt_d = cnt_q[i] - 16'h0001;
                        end
                    end
                end
                MODE_ONESHOT: begin
                    if (!start_q[i]) begin
                        os_run_d = 1'b0;
                        out_d = 1'b0;
                    end else if (!os_run_q) begin
                        if ((a_edge && a_q) || sw_trig[i]) begin // R6
                            os_run_d = 1'b1;
                            cnt_d = rel_q[i];
                            out_d = 1'b1;
                        end
                    end else if (tick) begin
                        if (cnt_q[i] <= 16'h0001) begin
                            os_run_d = 1'b0; // R6
                            out_d = 1'b0;
                            cnt_d = rel_q[i];
                            evt[i] = 1'b1;
                        end else begin
                            cnt_d = cnt_q[i] - 16'h0001;
                        end
                    end
                end
                MODE_PWM: begin
                    if (!start_q[i]) begin
                        out_d = 1'b0;
                    end else if (tick) begin
                        if (mode_q[i][PWM8_BIT] ?
                            cnt_q[i][7:0] == PWM8_LAST :
                            cnt_q[i] == PWM16_LAST) begin
                            cnt_d = 16'h0000; // R7
                            evt[i] = 1'b1;
                        end else begin
                            cnt_d = cnt_q[i] + 16'h0001;
                        end
                        out_d = mode_q[i][PWM8_BIT] ?
                            (cnt_d[7:0] < rel_q[i][15:8]) :
                            (cnt_d < rel_q[i]); // R7
                    end
                end
                default: begin
                    cnt_d = cnt_q[i];
                end
            endcase
            if (ch_wr[i]) begin
                rel_d = wdata_q[15:0]; // R10 R11
                if (!start_q[i]) begin
                    cnt_d = wdata_q[15:0]; // R10 R18
                end
            end
            if (!PIN_MASK[i]) begin
                out_d = 1'b0; // R2
            end
        end

        // counter and reload are data only, left without reset
        always_ff @(posedge aclk) begin
            cnt_q[i] <= cnt_d; // R1 R15
            rel_q[i] <= rel_d;
        end

        // pin output and one-shot state
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                out_q[i] <= 1'b0;
                os_run_q <= 1'b0;
            end else begin
                out_q[i] <= out_d;
                os_run_q <= os_run_d;
            end
        end

        chk_stopped_write: assert property (@(posedge aclk) // R10
            disable iff (!aresetn) ch_wr[i] && !start_q[i]
            |=> cnt_q[i] == $past(wdata_q[15:0]) &&
                rel_q[i] == $past(wdata_q[15:0]))
            else $error("stopped write did not load counter");
        chk_running_write: assert property (@(posedge aclk) // R11
            disable iff (!aresetn) ch_wr[i] && start_q[i] &&
            md == MODE_TIMER && !tick
            |=> $stable(cnt_q[i]) && rel_q[i] == $past(wdata_q[15:0]))
            else $error("running write touched counter");
        chk_count_down: assert property (@(posedge aclk) // R8
            disable iff (!aresetn) md == MODE_TIMER && start_q[i] &&
            tick && !mode_q[i][GATE_BIT] && cnt_q[i] != 16'h0000 &&
            !ch_wr[i] |=> cnt_q[i] == $past(cnt_q[i]) - 16'h0001)
            else $error("timer did not decrement");
        chk_underflow_reload: assert property (@(posedge aclk) // R9
            disable iff (!aresetn) md == MODE_TIMER && start_q[i] &&
            tick && !mode_q[i][GATE_BIT] && cnt_q[i] == 16'h0000
            |=> cnt_q[i] == $past(rel_q[i]) && status_q[i])
            else $error("underflow did not reload");
        chk_stopped_hold: assert property (@(posedge aclk) // R18
            disable iff (!aresetn) !start_q[i] && !ch_wr[i]
            && md != MODE_ONESHOT |=> $stable(cnt_q[i]))
            else $error("stopped channel changed count");
        if (!PIN_MASK[i]) begin : g_int
            chk_internal_timer: assert property (@(posedge aclk) // R2
                disable iff (!aresetn) md == MODE_TIMER && !out_q[i])
                else $error("internal channel left timer mode");
        end
    end

    chk_start_reset: assert property (@(posedge aclk) // R16
        !aresetn |=> start_q == '0 && !irq)
        else $error("start bits not cleared by reset");
    chk_read_count: assert property (@(posedge aclk) // R12
        disable iff (!aresetn) rd_fire &&
        s_axi_araddr == ADDR_W'({CH_INDEX[0], 2'b00})
        |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(cnt_q[0]))
        else $error("counter read mismatch");

endmodule : timer_bank

// file: pin_source.sv
// partner model: the external count pins of the timer bank
// assumes aclk from the bench; each pin level held for at least four cycles
module pin_source (
    input wire logic aclk,
    output logic [9:0] pin_a,
    output logic [9:0] pin_b
);
    timeunit 1ns;
    timeprecision 1ns;

    // pins idle low until a scenario asks for edges
    initial begin
        pin_a = 10'h000;
        pin_b = 10'h000;
    end

    // n rising edges on phase a of one channel, slow enough for the filter
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            repeat (4) @(posedge aclk);
            pin_a[ch] <= 1'b1;
            repeat (4) @(posedge aclk);
            pin_a[ch] <= 1'b0;
        end
    endtask : pulse

    // n quadrature cycles on one channel, phase a leading phase b
    task automatic quad(input int ch, input int n);
        repeat (n) begin
            repeat (4) @(posedge aclk);
            pin_a[ch] <= 1'b1;
            repeat (4) @(posedge aclk);
            pin_b[ch] <= 1'b1;
            repeat (4) @(posedge aclk);
            pin_a[ch] <= 1'b0;
            repeat (4) @(posedge aclk);
            pin_b[ch] <= 1'b0;
        end
    endtask : quad
endmodule : pin_source

// file: test_ten_channel_reload_timer_bank.sv
// self-checking bench for the ten channel reload timer bank
// assumes the register map of timer_bank_pkg and pin_source as pin driver
module test_ten_channel_reload_timer_bank import timer_bank_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    logic [9:0] pin_a, pin_b, chan_out;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;

    timer_bank dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .chan_in_a(pin_a), .chan_in_b(pin_b), .chan_out(chan_out),
        .irq(irq));
    pin_source pins (.aclk(aclk), .pin_a(pin_a), .pin_b(pin_b));

    // 50 ns clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // watchdog on a hang
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    function automatic logic [11:0] ch_addr(input int i);
        return {2'b00, CH_INDEX[i], 2'b00};
    endfunction : ch_addr

    // one write: address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr

    // one read: address held until taken, data taken with rvalid
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd

    // reset state and an unmapped address
    task automatic t_reset();
        rd(START_ADDR, got);
        chk(got, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd(12'h000, got, RESP_SLVERR);
        chk(got, 32'h0);
        wr(12'h000, 32'h0, RESP_SLVERR);
    endtask : t_reset

    // stopped writes land in the counter of every channel, 16 bits only
    task automatic t_stopped();
        for (int i = 0; i < NUM_CH; i++) begin
            wr(ch_addr(i), 32'h5A5A_1230 + i);
            rd(ch_addr(i), got);
            chk(got, 32'h0000_1230 + i);
        end
    endtask : t_stopped

    // running write reaches the counter only at reload; interrupt path
    task automatic t_running();
        wr(MODE_BASE + 12'h00C, 32'h180);
        wr(ch_addr(3), 32'h3);
        wr(MASK_ADDR, 32'h8);
        wr(START_ADDR, 32'h8);
        wr(ch_addr(3), 32'h8000);
        rd(ch_addr(3), got);
        chk(got & 32'hFFFC, 32'h0);
        repeat (3072) @(posedge aclk);
        rd(ch_addr(3), got);
        chk(got >> 4, 32'h7FF);
        chk({31'h0, irq}, 32'h1);
        rd(STATUS_ADDR, got);
        chk(got & 32'h8, 32'h8);
        wr(MASK_ADDR, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(START_ADDR, 32'h0);
        wr(STATUS_ADDR, 32'h8);
        rd(STATUS_ADDR, got);
        chk(got & 32'h8, 32'h0);
        wr(MODE_BASE + 12'h00C, 32'h1FF);
        rd(MODE_BASE + 12'h00C, got);
        chk(got, 32'h180);
    endtask : t_running

    // event counting on pin a, down then up
    task automatic t_event();
        for (int up = 0; up < 2; up++) begin
            wr(START_ADDR, 32'h0);
            wr(MODE_BASE, (up == 1) ? 32'h5 : 32'h1);
            wr(ch_addr(0), 32'h10);
            wr(START_ADDR, 32'h1);
            pins.pulse(0, 3);
            repeat (8) @(posedge aclk);
            rd(ch_addr(0), got);
            chk(got, (up == 1) ? 32'h13 : 32'hD);
        end
        wr(START_ADDR, 32'h0);
    endtask : t_event

    // software trigger gives one pulse that ends
    task automatic t_oneshot();
        wr(CLKDIV_ADDR, 32'h1);
        wr(MODE_BASE + 12'h004, 32'h2);
        wr(ch_addr(1), 32'h8);
        wr(START_ADDR, 32'h2);
        wr(TRIG_ADDR, 32'h2);
        @(posedge aclk);
        chk({31'h0, chan_out[1]}, 32'h1);
        repeat (30) @(posedge aclk);
        chk({31'h0, chan_out[1]}, 32'h0);
    endtask : t_oneshot

    // 8-bit PWM: 64 high cycles in every 256
    task automatic t_pwm();
        logic [31:0] n;
        n = 32'h0;
        wr(START_ADDR, 32'h0);
        wr(MODE_BASE + 12'h004, 32'h43);
        wr(ch_addr(1), 32'h4000);
        wr(START_ADDR, 32'h2);
        repeat (256) begin
            @(posedge aclk);
            n = n + chan_out[1];
        end
        chk(n, 32'h40);
        wr(START_ADDR, 32'h0);
    endtask : t_pwm

    // quadruple two-phase counting on channel 4
    task automatic t_quad();
        wr(MODE_BASE + 12'h010, 32'h21);
        wr(ch_addr(4), 32'h10);
        wr(START_ADDR, 32'h10);
        pins.quad(4, 2);
        repeat (8) @(posedge aclk);
        rd(ch_addr(4), got);
        chk(got, 32'h18);
        wr(START_ADDR, 32'h0);
    endtask : t_quad

    // reset for four cycles, then the scenarios
    initial begin
        aresetn = 1'b0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_stopped();
        t_running();
        t_event();
        t_oneshot();
        t_pwm();
        t_quad();
        conclude();
    end
endmodule : test_ten_channel_reload_timer_bank
